// >>> hdl/ppm_pkg.sv
// Shared constants and carrier types for the port pin sharing mux
package ppm_pkg;

    localparam int NUM_PORTS = 7;
    localparam int PORT_W    = 8;

    // Port indices
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    localparam logic [2:0] PORT_F = 3'h5;
    localparam logic [2:0] PORT_G = 3'h6;

    // Pin positions of shared functions
    localparam int C_SECOND_SERIAL_TRANSMIT_BIT  = 0;
    localparam int C_SECOND_SERIAL_RECEIVE_BIT  = 1;
    localparam int C_SDA_BIT   = 2;
    localparam int C_SCL_BIT   = 3;
    localparam int D_TMR1_LO   = 0;
    localparam int D_TMR1_CH   = 3;
    localparam int D_TMR2_LO   = 3;
    localparam int D_TMR2_CH   = 5;
    localparam int D_TMR1_CLK  = 0;
    localparam int D_TMR2_CLK  = 3;
    localparam int E_FIRST_SERIAL_TRANSMIT_BIT  = 0;
    localparam int E_FIRST_SERIAL_RECEIVE_BIT  = 1;
    localparam int E_SPI_LO    = 2;
    localparam int E_SPI_W     = 4;
    localparam int G_BKGD_BIT  = 0;
    localparam int G_CRYSTAL_OUTPUT_BIT  = 1;
    localparam int G_CRYSTAL_INPUT_BIT = 2;

    // Reset values
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic       RST_BKGD_PE = 1'b1;

    // Register select on the write port
    typedef enum logic [1:0] {
        PPM_REG_DATA = 2'h0,
        PPM_REG_DIR  = 2'h1,
        PPM_REG_PUE  = 2'h2,
        PPM_REG_SLEW = 2'h3
    } ppm_reg_t;

    typedef logic [NUM_PORTS-1:0][PORT_W-1:0] ppm_bank_t;

    // Pad-side controls for all pins
    typedef struct packed {
        ppm_bank_t out;
        ppm_bank_t oe_n;
        ppm_bank_t pull;
        ppm_bank_t slew;
    } ppm_pad_t;

    // Requests from the on-chip peripherals
    typedef struct packed {
        logic [7:0] kbi_en;
        logic       adc_en;
        logic [7:0] adc_pin_en;
        logic       second_async_serial_unit_en;
        logic       second_async_serial_unit_txd;
        logic       iic_en;
        logic       sda_low;
        logic       scl_low;
        logic [2:0] tmr1_en;
        logic [2:0] tmr1_oe;
        logic [2:0] tmr1_out;
        logic       tmr1_clk_en;
        logic [4:0] tmr2_en;
        logic [4:0] tmr2_oe;
        logic [4:0] tmr2_out;
        logic       tmr2_clk_en;
        logic       first_async_serial_unit_en;
        logic       first_async_serial_unit_txd;
        logic       spi_en;
        logic [3:0] spi_oe;
        logic [3:0] spi_out;
        logic       bkgd_drive;
        logic       bkgd_out;
        logic       osc_en;
    } ppm_periph_t;

    // Whole register state of the mux
    typedef struct packed {
        ppm_bank_t  data;
        ppm_bank_t  dir;
        ppm_bank_t  pue;
        ppm_bank_t  slew;
        logic       bkgd_pe;
        logic       mode_sel;
        logic [7:0] rd_data;
    } ppm_state_t;

endpackage

// >>> hdl/ppm_pin_mux.sv
// Pin sharing mux for seven 8-bit parallel ports and their peripherals
`timescale 1ns/10ps
`default_nettype none

module ppm_pin_mux
    import ppm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_en_i,
    input  wire logic [2:0]  wr_port_i,
    input  wire ppm_reg_t    wr_reg_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic [2:0]  rd_port_i,
    output logic [7:0]       rd_data_o,
    input  wire logic        bkgd_pe_clr_i,
    output logic             bkgd_pe_o,
    output logic             mode_select_o,
    input  wire ppm_periph_t periph_i,
    input  wire ppm_bank_t   pin_i,
    output ppm_pad_t         pad_o
);

    ppm_state_t st;
    ppm_state_t next_st;
    ppm_bank_t  own;
    ppm_bank_t  per_drv;
    ppm_bank_t  per_out;
    ppm_bank_t  force_pu;
    ppm_bank_t  gpio_drv;

    ////////////////////////////////////////////////////////////////////////
    // Peripheral claims

    always_comb
    begin
        own      = '0;
        per_drv  = '0;
        per_out  = '0;
        force_pu = '0;

        own[PORT_A] = periph_i.kbi_en;
        if (periph_i.adc_en)
        begin
            own[PORT_B] = periph_i.adc_pin_en;
        end

        if (periph_i.second_async_serial_unit_en)
        begin
            own[PORT_C][C_SECOND_SERIAL_TRANSMIT_BIT]     = 1'b1;
            own[PORT_C][C_SECOND_SERIAL_RECEIVE_BIT]     = 1'b1;
            per_drv[PORT_C][C_SECOND_SERIAL_TRANSMIT_BIT] = 1'b1;
            per_out[PORT_C][C_SECOND_SERIAL_TRANSMIT_BIT] = periph_i.second_async_serial_unit_txd;
        end
        if (periph_i.iic_en)
        begin
            // Open drain: only ever pulls low
            own[PORT_C][C_SDA_BIT]     = 1'b1;
            own[PORT_C][C_SCL_BIT]     = 1'b1;
            per_drv[PORT_C][C_SDA_BIT] = periph_i.sda_low;
            per_drv[PORT_C][C_SCL_BIT] = periph_i.scl_low;
        end

        for (int i = 0; i < D_TMR1_CH; i++)
        begin
            if (periph_i.tmr1_en[i])
            begin
                own[PORT_D][D_TMR1_LO+i]     = 1'b1;
                per_drv[PORT_D][D_TMR1_LO+i] = periph_i.tmr1_oe[i];
                per_out[PORT_D][D_TMR1_LO+i] = periph_i.tmr1_out[i];
            end
        end
        for (int i = 0; i < D_TMR2_CH; i++)
        begin
            if (periph_i.tmr2_en[i])
            begin
                own[PORT_D][D_TMR2_LO+i]     = 1'b1;
                per_drv[PORT_D][D_TMR2_LO+i] = periph_i.tmr2_oe[i];
                per_out[PORT_D][D_TMR2_LO+i] = periph_i.tmr2_out[i];
            end
        end
        // External clock inputs override any channel use of the pin
        if (periph_i.tmr1_clk_en)
        begin
            own[PORT_D][D_TMR1_CLK]     = 1'b1;
            per_drv[PORT_D][D_TMR1_CLK] = 1'b0;
        end
        if (periph_i.tmr2_clk_en)
        begin
            own[PORT_D][D_TMR2_CLK]     = 1'b1;
            per_drv[PORT_D][D_TMR2_CLK] = 1'b0;
        end

        if (periph_i.first_async_serial_unit_en)
        begin
            own[PORT_E][E_FIRST_SERIAL_TRANSMIT_BIT]     = 1'b1;
            own[PORT_E][E_FIRST_SERIAL_RECEIVE_BIT]     = 1'b1;
            per_drv[PORT_E][E_FIRST_SERIAL_TRANSMIT_BIT] = 1'b1;
            per_out[PORT_E][E_FIRST_SERIAL_TRANSMIT_BIT] = periph_i.first_async_serial_unit_txd;
        end
        if (periph_i.spi_en)
        begin
            for (int i = 0; i < E_SPI_W; i++)
            begin
                own[PORT_E][E_SPI_LO+i]     = 1'b1;
                per_drv[PORT_E][E_SPI_LO+i] = periph_i.spi_oe[i];
                per_out[PORT_E][E_SPI_LO+i] = periph_i.spi_out[i];
            end
        end

        // Port F has no claimants at all

        if (st.bkgd_pe)
        begin
            own[PORT_G][G_BKGD_BIT]      = 1'b1;
            per_drv[PORT_G][G_BKGD_BIT]  = periph_i.bkgd_drive;
            per_out[PORT_G][G_BKGD_BIT]  = periph_i.bkgd_out;
            force_pu[PORT_G][G_BKGD_BIT] = 1'b1;
        end
        if (periph_i.osc_en)
        begin
            own[PORT_G][G_CRYSTAL_OUTPUT_BIT]  = 1'b1;
            own[PORT_G][G_CRYSTAL_INPUT_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad drive

    always_comb
    begin
        gpio_drv = st.dir & ~own;
        pad_o.out  = (own & per_out) | (~own & st.data);
        pad_o.oe_n = ~((own & per_drv) | gpio_drv);
        // Pullup only where the pin is not being driven, except the forced pullup on the background pin
        pad_o.pull = force_pu | (st.pue & ~st.dir & ~(own & per_drv));
        pad_o.slew = st.slew & ~pad_o.oe_n;
        // Output-only pin has no pullup path as GPIO
        if (!st.bkgd_pe)
        begin
            pad_o.pull[PORT_G][G_BKGD_BIT] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_comb
    begin
        next_st = st;
        if (wr_en_i && (wr_port_i <= PORT_G))
        begin
            case (wr_reg_i)
                PPM_REG_DATA: next_st.data[wr_port_i] = wr_data_i;
                PPM_REG_DIR:  next_st.dir[wr_port_i]  = wr_data_i;
                PPM_REG_PUE:  next_st.pue[wr_port_i]  = wr_data_i;
                PPM_REG_SLEW: next_st.slew[wr_port_i] = wr_data_i;
                default:      next_st = st;
            endcase
        end
        if (bkgd_pe_clr_i)
        begin
            next_st.bkgd_pe = 1'b0;
        end

        // Read path: direction selects pin or latch even when overridden
        if (rd_port_i <= PORT_G)
        begin
            next_st.rd_data = (st.dir[rd_port_i] & st.data[rd_port_i])
                            | (~st.dir[rd_port_i] & pin_i[rd_port_i]);
            if (rd_port_i == PORT_G)
            begin
                // No input buffer on the output-only pin
                next_st.rd_data[G_BKGD_BIT] =
                    st.data[PORT_G][G_BKGD_BIT];
            end
        end
        else
        begin
            next_st.rd_data = RST_BYTE;
        end

        if (rst_i)
        begin
            next_st.data    = '0;
            next_st.dir     = '0;
            next_st.pue     = '0;
            next_st.slew    = '0;
            next_st.bkgd_pe = RST_BKGD_PE;
            next_st.rd_data = RST_BYTE;
            next_st.mode_sel = pin_i[PORT_G][G_BKGD_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        st <= next_st;
    end

    assign rd_data_o     = st.rd_data;
    assign bkgd_pe_o     = st.bkgd_pe;
    assign mode_select_o = st.mode_sel;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_reset_clears_dir: assert property (
        @(posedge clk_i) rst_i |=> (st.dir == '0) && (st.pue == '0)
            && st.bkgd_pe)
        else $error("reset did not clear direction and pullups");

    a_keypad_forces_in: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.kbi_en != '0 |-> (pad_o.oe_n[PORT_A] & periph_i.kbi_en)
            == periph_i.kbi_en)
        else $error("keypad pin driven");

    a_adc_forces_in: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.adc_en |-> ((pad_o.oe_n[PORT_B] & periph_i.adc_pin_en)
            == periph_i.adc_pin_en)
            && ((pad_o.oe_n[PORT_B] | periph_i.adc_pin_en)
            == (~st.dir[PORT_B] | periph_i.adc_pin_en)))
        else $error("converter pin selection wrong");

    a_port_f_plain: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pad_o.oe_n[PORT_F] == ~st.dir[PORT_F]
            && pad_o.out[PORT_F] == st.data[PORT_F])
        else $error("port F not under plain control");

    a_second_async_serial_unit_transmit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.second_async_serial_unit_en |-> !pad_o.oe_n[PORT_C][C_SECOND_SERIAL_TRANSMIT_BIT]
            && pad_o.out[PORT_C][C_SECOND_SERIAL_TRANSMIT_BIT] == periph_i.second_async_serial_unit_txd
            && pad_o.oe_n[PORT_C][C_SECOND_SERIAL_RECEIVE_BIT])
        else $error("second serial pins wrong");

    a_bkgd_pullup_on: assert property (
        @(posedge clk_i) disable iff (rst_i)
        st.bkgd_pe |-> pad_o.pull[PORT_G][G_BKGD_BIT]
            && pad_o.oe_n[PORT_G][G_BKGD_BIT] == !periph_i.bkgd_drive)
        else $error("background pin not owned");

    a_bkgd_pe_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !st.bkgd_pe |=> !st.bkgd_pe)
        else $error("background enable came back without reset");

    a_read_latch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_port_i == PORT_F) && (st.dir[PORT_F] == 8'hFF)
            |=> rd_data_o == $past(st.data[PORT_F]))
        else $error("readback of output latch wrong");

    // Latch must take the byte whether or not the keypad owns the pins
    a_write_latches: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en_i && wr_port_i == PORT_A && wr_reg_i == PPM_REG_DATA
            |=> st.data[PORT_A] == $past(wr_data_i))
        else $error("data write not latched under override");

    // Open drain: the bus unit may only pull low, never drive high
    a_iic_open_drain: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.iic_en |-> !pad_o.out[PORT_C][C_SDA_BIT]
            && !pad_o.out[PORT_C][C_SCL_BIT]
            && pad_o.oe_n[PORT_C][C_SDA_BIT] == !periph_i.sda_low
            && pad_o.oe_n[PORT_C][C_SCL_BIT] == !periph_i.scl_low)
        else $error("two-wire pins wrong");

    a_tmr1_clock_in: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.tmr1_clk_en |-> pad_o.oe_n[PORT_D][D_TMR1_CLK])
        else $error("first timer clock pin driven");

    a_tmr2_clock_in: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.tmr2_clk_en |-> pad_o.oe_n[PORT_D][D_TMR2_CLK])
        else $error("second timer clock pin driven");

    a_first_async_serial_unit_transmit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.first_async_serial_unit_en |-> !pad_o.oe_n[PORT_E][E_FIRST_SERIAL_TRANSMIT_BIT]
            && pad_o.out[PORT_E][E_FIRST_SERIAL_TRANSMIT_BIT] == periph_i.first_async_serial_unit_txd
            && pad_o.oe_n[PORT_E][E_FIRST_SERIAL_RECEIVE_BIT])
        else $error("first serial pins wrong");

    a_spi_pins_owned: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.spi_en
            |-> pad_o.oe_n[PORT_E][E_SPI_LO +: E_SPI_W] == ~periph_i.spi_oe
            && pad_o.out[PORT_E][E_SPI_LO +: E_SPI_W] == periph_i.spi_out)
        else $error("sync serial pins wrong");

    // Oscillator pins must never see the port driver fight the crystal
    a_osc_undriven: assert property (
        @(posedge clk_i) disable iff (rst_i)
        periph_i.osc_en |-> pad_o.oe_n[PORT_G][G_CRYSTAL_OUTPUT_BIT]
            && pad_o.oe_n[PORT_G][G_CRYSTAL_INPUT_BIT])
        else $error("oscillator pin driven");

    // Mode is latched only while reset stands
    a_mode_held: assert property (
        @(posedge clk_i)
        !rst_i |=> $stable(st.mode_sel))
        else $error("mode select changed outside reset");

endmodule

`default_nettype wire

// >>> bench/ppm_pin_load.sv
// Pin load model: pads, external drivers and pullups resolved per pin
`timescale 1ns/10ps
`default_nettype none

module ppm_pin_load
    import ppm_pkg::*;
(
    input  wire logic      clk_i,
    input  wire ppm_pad_t  pad_i,
    input  wire ppm_bank_t ext_i,
    input  wire ppm_bank_t ext_en_i,
    output ppm_bank_t      pin_o
);
    // Floating pins toggle so no read can lean on a settled value
    logic flt;

    always_ff @(posedge clk_i)
        flt <= (flt === 1'b1) ? 1'b0 : 1'b1;

    always_comb
        for (int p = 0; p < NUM_PORTS; p++)
            for (int b = 0; b < PORT_W; b++)
                if (!pad_i.oe_n[p][b])
                    pin_o[p][b] = pad_i.out[p][b];
                else if (ext_en_i[p][b])
                    pin_o[p][b] = ext_i[p][b];
                else
                    pin_o[p][b] = pad_i.pull[p][b] | flt;
endmodule

`default_nettype wire

// >>> bench/ppm_pin_mux_tb_top.sv
// Self-checking testbench for the port pin sharing mux
`timescale 1ns/10ps
`default_nettype none

module ppm_pin_mux_tb_top
    import ppm_pkg::*;
;
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        wr_en    = 1'b0;
    logic [2:0]  wr_port  = 3'h0;
    ppm_reg_t    wr_reg   = PPM_REG_DATA;
    logic [7:0]  wr_data  = 8'h00;
    logic [2:0]  rd_port  = 3'h0;
    logic        bkgd_clr = 1'b0;
    ppm_periph_t per      = '0;
    // G0 left to its pullup so mode select reads high
    ppm_bank_t   ext      = {7{8'h3C}};
    ppm_bank_t   ext_en   = {8'hFE, {6{8'hFF}}};
    logic [7:0]  rd_data;
    logic        bkgd_pe;
    logic        mode_sel;
    ppm_bank_t   pin;
    ppm_pad_t    pad;
    int          fails    = 0;
    int          compares = 0;

    ppm_pin_mux uut (.clk_i(clk), .rst_i(rst), .wr_en_i(wr_en),
        .wr_port_i(wr_port), .wr_reg_i(wr_reg), .wr_data_i(wr_data),
        .rd_port_i(rd_port), .rd_data_o(rd_data), .bkgd_pe_clr_i(bkgd_clr),
        .bkgd_pe_o(bkgd_pe), .mode_select_o(mode_sel), .periph_i(per),
        .pin_i(pin), .pad_o(pad));

    ppm_pin_load load (.clk_i(clk), .pad_i(pad), .ext_i(ext),
        .ext_en_i(ext_en), .pin_o(pin));

    initial
    begin
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
            fails++;
        end
    endtask

    // Strobe drops on the taking edge, so calls are never back to back
    task wr(input logic [2:0] p, input ppm_reg_t r, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_port <= p;
        wr_reg <= r;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task rd(input logic [2:0] p, input logic [7:0] e);
        @(posedge clk) rd_port <= p;
        @(posedge clk);
        #1 chk(rd_data, e);
    endtask

    task wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task t_reset;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            chk(pad.oe_n[p], 8'hFF);
            chk(pad.pull[p], (p == 6) ? 8'h01 : 8'h00);
        end
        chk({7'h00, bkgd_pe}, 8'h01);
        chk({7'h00, mode_sel}, 8'h01);
        chk(rd_data, 8'h00);
    endtask

    task t_gpio;
        wr(PORT_F, PPM_REG_DATA, 8'h5A);
        chk(pad.oe_n[PORT_F], 8'hFF);
        wr(PORT_F, PPM_REG_DIR, 8'hFF);
        chk(pad.oe_n[PORT_F], 8'h00);
        chk(pad.out[PORT_F], 8'h5A);
        wr(PORT_F, PPM_REG_SLEW, 8'hFF);
        chk(pad.slew[PORT_F], 8'hFF);
        rd(PORT_F, 8'h5A);
        rd(PORT_A, 8'h3C);
        wr(PORT_A, PPM_REG_PUE, 8'hFF);
        chk(pad.pull[PORT_A], 8'hFF);
        wr(3'h7, PPM_REG_DIR, 8'hFF);
        rd(3'h7, 8'h00);
    endtask

    task t_kbi_adc;
        wr(PORT_A, PPM_REG_DIR, 8'hFF);
        @(posedge clk) per.kbi_en <= 8'h0F;
        #1 chk(pad.oe_n[PORT_A], 8'h0F);
        rd(PORT_A, 8'h00);
        wr(PORT_A, PPM_REG_DATA, 8'hA5);
        chk(pad.out[PORT_A], 8'hA0);
        rd(PORT_A, 8'hA5);
        @(posedge clk) per.kbi_en <= 8'h00;
        #1 chk(pad.oe_n[PORT_A], 8'h00);
        wr(PORT_B, PPM_REG_DIR, 8'hFF);
        @(posedge clk) per.adc_pin_en <= 8'hF0;
        #1 chk(pad.oe_n[PORT_B], 8'h00);
        @(posedge clk) per.adc_en <= 1'b1;
        #1 chk(pad.oe_n[PORT_B], 8'hF0);
    endtask

    task t_portc;
        wr(PORT_C, PPM_REG_DATA, 8'hFF);
        wr(PORT_C, PPM_REG_DIR, 8'hFF);
        @(posedge clk) {per.second_async_serial_unit_en, per.second_async_serial_unit_txd} <= 2'h2;
        #1 chk(pad.oe_n[PORT_C], 8'h02);
        chk(pad.out[PORT_C] & 8'h01, 8'h00);
        @(posedge clk) {per.second_async_serial_unit_en, per.iic_en, per.sda_low} <= 3'h3;
        #1 chk(pad.oe_n[PORT_C], 8'h08);
        chk(pad.out[PORT_C] & 8'h04, 8'h00);
    endtask

    task t_portd;
        @(posedge clk) {per.tmr1_en, per.tmr1_oe} <= 6'h3D;
        #1 chk(pad.oe_n[PORT_D], 8'hFA);
        @(posedge clk) per.tmr1_clk_en <= 1'b1;
        #1 chk(pad.oe_n[PORT_D], 8'hFB);
        @(posedge clk)
            {per.tmr1_en, per.tmr2_en, per.tmr2_oe, per.tmr2_out} <= 18'h07FF5;
        #1 chk(pad.oe_n[PORT_D], 8'h07);
        chk(pad.out[PORT_D] & 8'hF8, 8'hA8);
        @(posedge clk) per.tmr2_clk_en <= 1'b1;
        #1 chk(pad.oe_n[PORT_D], 8'h0F);
    endtask

    task t_porte;
        wr(PORT_E, PPM_REG_DATA, 8'hFF);
        @(posedge clk)
            {per.first_async_serial_unit_en, per.first_async_serial_unit_txd, per.spi_en, per.spi_oe} <= 7'h5A;
        #1 chk(pad.oe_n[PORT_E], 8'hD6);
        chk(pad.out[PORT_E] & 8'h01, 8'h00);
        chk(pad.oe_n[PORT_F], 8'h00);
    endtask

    task t_portg;
        wr(PORT_G, PPM_REG_DATA, 8'hFF);
        wr(PORT_G, PPM_REG_DIR, 8'hFF);
        @(posedge clk) per.osc_en <= 1'b1;
        #1 chk(pad.oe_n[PORT_G], 8'h07);
        chk(pad.pull[PORT_G] & 8'h01, 8'h01);
        @(posedge clk) {per.bkgd_drive, per.bkgd_out} <= 2'h2;
        #1 chk(pad.oe_n[PORT_G], 8'h06);
        chk(pad.out[PORT_G] & 8'h01, 8'h00);
        @(posedge clk) {per.bkgd_drive, bkgd_clr} <= 2'h1;
        @(posedge clk) bkgd_clr <= 1'b0;
        #1 chk({7'h00, bkgd_pe}, 8'h00);
        chk(pad.oe_n[PORT_G], 8'h06);
        chk(pad.out[PORT_G] & 8'h01, 8'h01);
        rd(PORT_G, 8'hFF);
        @(posedge clk) per <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 t_reset;
        t_gpio;
        t_kbi_adc;
        t_portc;
        t_portd;
        t_porte;
        t_portg;
        // Second reset in mid-run must restore every default
        @(posedge clk) rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 t_reset;
        wrap_up;
    end

    initial
    begin
        #400000;
        fails++;
        wrap_up;
    end
endmodule

`default_nettype wire
